// *** inc/acs_pkg.sv ***
// Constants and carrier types for the A/D conversion sequencer.
// Assumes a single 25 MHz system clock and synchronous active-high reset.
// Function
// - Each conversion is 4 sampling then 12 converting A/D clock cycles, 16 total.
// - Result written at conversion end, then latched half an A/D clock later.
// - Start set within that half cycle lets the stored result be altered.
// - Conversion begins on a full low-high-low sequence of the start control.
// - Busy is 1 during conversion, cleared at completion; result then readable.
// - Source select 000 takes the pin channel; other values pick internal sources.
// - Four-bit reference select picks reference pin, analog supply or bandgap.
// - Format select bit arranges the 12-bit result within high and low bytes.
// - A/D clock derived from system clock by the three-bit divider select.
// - Enable cleared switches converter circuits off, drawing no power.
// - Result is 12-bit unsigned with full-scale code FFF hex.
// - One code step equals selected reference divided by 4096.
// - Transitions sit 0.5 LSB low; last one 1.5 LSB below reference.
// - Start high but not yet low resets converter and clears busy.
// - Completion sets request flag; raises interrupt when enabled.
package acs_pkg;
	localparam int ACS_RES_W = 12;
	localparam int ACS_SAMPLE_CYC = 4;
	localparam int ACS_CONV_CYC = 12;
	localparam int ACS_TOTAL_CYC = ACS_SAMPLE_CYC + ACS_CONV_CYC;
	localparam logic [11:0] ACS_FULL_SCALE = 12'hFFF;
	localparam int ACS_LSB_DIV = 4096;
	localparam logic [2:0] ACS_SRC_PIN = 3'h0;
	localparam logic [3:0] ACS_REF_AVDD = 4'h0;
	localparam logic [3:0] ACS_REF_EXT_LO = 4'h1;
	localparam logic [3:0] ACS_REF_EXT_HI = 4'h4;
	localparam logic [3:0] ACS_REF_BG_LO = 4'hA;
	localparam logic [3:0] ACS_REF_BG_HI = 4'hC;
	localparam int ACS_MAX_DIV_EXP = 7;
	localparam int ACS_CLK_MHZ = 25;

	typedef struct packed {
		logic converter_power_enable;
		logic [2:0] conv_clock_divider_sel;
		logic [2:0] internal_source_sel;
		logic [3:0] pin_channel_sel;
		logic [3:0] reference_source_sel;
		logic result_format_sel;
	} acs_cfg_t;

	typedef struct packed {
		logic sample_en;
		logic comp_en;
		logic use_pin;
		logic [3:0] pin_channel;
		logic [2:0] internal_source;
		logic ref_ext_pin;
		logic ref_avdd;
		logic ref_bandgap;
	} acs_analog_t;

	typedef enum logic [1:0] {ACS_IDLE, ACS_ARMED, ACS_SAMPLE, ACS_CONVERT} acs_state_t;
endpackage

// *** src/acs_clkdiv.sv ***
// Divider that makes the A/D clock as enable pulses from the system clock.
// Assumes mclk at 25 MHz; emits a full-period and a half-period pulse.
`timescale 1ns/1ps
module acs_clkdiv
	import acs_pkg::*;
#(
	parameter int CNT_W = ACS_MAX_DIV_EXP
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Control
	input wire logic run,
	input wire logic [2:0] div_sel,
	// Enables
	output logic tick,
	output logic half_tick
);
	if (CNT_W < ACS_MAX_DIV_EXP) begin
		$error("acs_clkdiv: counter too narrow");
	end

	logic [CNT_W-1:0] cnt_q, cnt_d, limit;
	logic tick_d, half_d, tick_q, half_q;

	always_comb begin
		limit = CNT_W'((32'd1 << div_sel) - 32'd1);
		cnt_d = cnt_q;
		tick_d = 1'b0;
		half_d = 1'b0;
		if (run) begin
			if (cnt_q >= limit) begin
				cnt_d = '0;
				tick_d = 1'b1;
			end else begin
				cnt_d = cnt_q + CNT_W'(1);
			end
			half_d = (cnt_q == (limit >> 1));
		end else begin
			cnt_d = '0;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			cnt_q <= '0;
			tick_q <= 1'b0;
			half_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tick_q <= tick_d;
			half_q <= half_d;
		end
	end

	assign tick = tick_q;
	assign half_tick = half_q;
endmodule

// *** src/acs_sequencer.sv ***
// A/D conversion sequencer: start handshake, timing, result latch, request flag.
// Assumes synchronous control ports and a comparator returning one bit per step.
`timescale 1ns/1ps
module acs_sequencer
	import acs_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Configuration
	input wire acs_cfg_t cfg,
	input wire logic start_ctl,
	input wire logic global_irq_enable,
	input wire logic conv_irq_enable,
	input wire logic irq_clear,
	// Analog front end
	input wire logic comp_out,
	output acs_analog_t analog_ctl,
	output logic [ACS_RES_W-1:0] dac_code,
	// Status and result
	output logic conv_busy_flag,
	output logic conv_irq_request,
	output logic irq_out,
	output logic [7:0] result_high_byte,
	output logic [7:0] result_low_byte
);
	acs_state_t st_q, st_d;
	logic [4:0] cyc_q, cyc_d;
	logic [ACS_RES_W-1:0] sar_q, sar_d, stored_q, stored_d;
	logic [ACS_RES_W-1:0] latched_q, latched_d;
	logic pend_q, pend_d;
	logic busy_q, busy_d, flag_q, flag_d, irq_q, irq_d;
	logic start_q;
	logic [7:0] hi_q, hi_d, lo_q, lo_d;
	acs_analog_t ana_q, ana_d;
	logic tick, half_tick, en, rise, fall;

	assign en = cfg.converter_power_enable;
	assign rise = start_ctl & ~start_q;
	assign fall = ~start_ctl & start_q;

	acs_clkdiv #(.CNT_W(ACS_MAX_DIV_EXP)) u_div (
		.mclk(mclk),
		.rst(rst),
		.run(en),
		.div_sel(cfg.conv_clock_divider_sel),
		.tick(tick),
		.half_tick(half_tick)
	);

	always_comb begin
		st_d = st_q;
		cyc_d = cyc_q;
		sar_d = sar_q;
		stored_d = stored_q;
		latched_d = latched_q;
		pend_d = pend_q;
		busy_d = busy_q;
		flag_d = flag_q;
		if (irq_clear)
			flag_d = 1'b0;
		case (st_q)
			ACS_IDLE: begin
				if (rise && en) begin
					st_d = ACS_ARMED;
					busy_d = 1'b0;
				end
			end
			ACS_ARMED: begin
				if (fall) begin
					st_d = ACS_SAMPLE;
					cyc_d = '0;
					busy_d = 1'b1;
					sar_d = '0;
					sar_d[ACS_RES_W-1] = 1'b1;
				end
			end
			ACS_SAMPLE: begin
				if (tick) begin
					cyc_d = cyc_q + 5'h1;
					if (cyc_q == 5'(ACS_SAMPLE_CYC - 1))
						st_d = ACS_CONVERT;
				end
			end
			ACS_CONVERT: begin
				if (tick) begin
					cyc_d = cyc_q + 5'h1;
					sar_d = sar_q;
					sar_d[ACS_TOTAL_CYC - 1 - int'(cyc_q)] = comp_out;
					if (cyc_q != 5'(ACS_TOTAL_CYC - 1))
						sar_d[ACS_TOTAL_CYC - 2 - int'(cyc_q)] = 1'b1;
					if (cyc_q == 5'(ACS_TOTAL_CYC - 1)) begin
						st_d = ACS_IDLE;
						busy_d = 1'b0;
						stored_d = sar_q;
						stored_d[0] = comp_out;
						pend_d = 1'b1;
						flag_d = 1'b1;
					end
				end
			end
			default: st_d = ACS_IDLE;
		endcase
		if (pend_q && rise && en)
			stored_d = '0;
		if (pend_q && half_tick) begin
			pend_d = 1'b0;
			latched_d = stored_d;
		end
		if ((st_q == ACS_SAMPLE || st_q == ACS_CONVERT) && rise) begin
			st_d = ACS_ARMED;
			busy_d = 1'b0;
		end
		if (!en) begin
			st_d = ACS_IDLE;
			busy_d = 1'b0;
			pend_d = 1'b0;
		end
	end

	always_comb begin
		if (cfg.result_format_sel) begin
			hi_d = {4'h0, latched_q[11:8]};
			lo_d = latched_q[7:0];
		end else begin
			hi_d = latched_q[11:4];
			lo_d = {latched_q[3:0], 4'h0};
		end
	end

	assign irq_d = flag_q & global_irq_enable & conv_irq_enable;

	always_comb begin
		ana_d = '0;
		if (en) begin
			ana_d.sample_en = (st_q == ACS_SAMPLE);
			ana_d.comp_en = (st_q == ACS_CONVERT);
			ana_d.use_pin = (cfg.internal_source_sel == ACS_SRC_PIN);
			ana_d.pin_channel = cfg.pin_channel_sel;
			ana_d.internal_source = cfg.internal_source_sel;
			ana_d.ref_ext_pin = (cfg.reference_source_sel >= ACS_REF_EXT_LO)
				&& (cfg.reference_source_sel <= ACS_REF_EXT_HI);
			ana_d.ref_bandgap = (cfg.reference_source_sel >= ACS_REF_BG_LO)
				&& (cfg.reference_source_sel <= ACS_REF_BG_HI);
			// Inhibited and unlisted codes fall back to the analog supply
			ana_d.ref_avdd = !ana_d.ref_ext_pin && !ana_d.ref_bandgap;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			st_q <= ACS_IDLE;
			cyc_q <= '0;
			sar_q <= '0;
			stored_q <= '0;
			latched_q <= '0;
			pend_q <= 1'b0;
			busy_q <= 1'b0;
			flag_q <= 1'b0;
			irq_q <= 1'b0;
			start_q <= 1'b0;
			hi_q <= '0;
			lo_q <= '0;
			ana_q <= '0;
		end else begin
			st_q <= st_d;
			cyc_q <= cyc_d;
			sar_q <= sar_d;
			stored_q <= stored_d;
			latched_q <= latched_d;
			pend_q <= pend_d;
			busy_q <= busy_d;
			flag_q <= flag_d;
			irq_q <= irq_d;
			start_q <= start_ctl;
			hi_q <= hi_d;
			lo_q <= lo_d;
			ana_q <= ana_d;
		end
	end

	assign dac_code = sar_q;
	assign analog_ctl = ana_q;
	assign conv_busy_flag = busy_q;
	assign conv_irq_request = flag_q;
	assign irq_out = irq_q;
	assign result_high_byte = hi_q;
	assign result_low_byte = lo_q;
endmodule

// *** verif/acs_sva.sv ***
// Port checker for the conversion sequencer.
// Assumes bind onto acs_sequencer; one clock domain.
`timescale 1ns/1ps
module acs_sva
	import acs_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Controls
	input wire acs_cfg_t cfg,
	input wire logic start_ctl,
	input wire logic global_irq_enable,
	input wire logic conv_irq_enable,
	input wire logic irq_clear,
	// Status
	input wire acs_analog_t analog_ctl,
	input wire logic conv_busy_flag,
	input wire logic conv_irq_request,
	input wire logic irq_out,
	input wire logic [7:0] result_high_byte,
	input wire logic [7:0] result_low_byte
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	a_busy_launch: assert property ($fell(start_ctl) && cfg.converter_power_enable
		|-> ##[1:2] conv_busy_flag) else $error("busy not raised");
	a_rise_abort: assert property ($rose(start_ctl) |=> !conv_busy_flag)
		else $error("busy kept on start rise");
	a_off_idle: assert property (!cfg.converter_power_enable
		|=> !conv_busy_flag && analog_ctl == '0) else $error("active while off");
	a_done_flag: assert property ($fell(conv_busy_flag) && !start_ctl
		&& cfg.converter_power_enable |-> ##[0:1] conv_irq_request) else $error("no flag");
	a_flag_sticky: assert property (conv_irq_request && !irq_clear
		|=> conv_irq_request) else $error("flag lost");
	a_flag_clear: assert property (irq_clear && !conv_busy_flag
		|=> !conv_irq_request) else $error("flag not cleared");
	a_busy_min: assert property ($rose(conv_busy_flag) |=> (conv_busy_flag
		|| start_ctl || !cfg.converter_power_enable) [*8]) else $error("busy too short");
	a_byte_format: assert property ($changed({result_high_byte, result_low_byte})
		&& $stable(cfg.result_format_sel) |-> (cfg.result_format_sel ?
		result_high_byte[7:4] == 4'h0 : result_low_byte[3:0] == 4'h0)) else $error("bad format");
	a_src_pin: assert property (conv_busy_flag |-> analog_ctl.use_pin
		== (cfg.internal_source_sel == ACS_SRC_PIN)) else $error("bad source");
	a_irq_out: assert property ($rose(conv_irq_request) && global_irq_enable
		&& conv_irq_enable |=> irq_out) else $error("no irq");
	a_irq_mask: assert property (!(global_irq_enable && conv_irq_enable) |=> !irq_out)
		else $error("irq not masked");
endmodule

// *** verif/testbench.sv ***
// Self-checking bench for the conversion sequencer.
// Assumes acs_pkg; the comparator is modelled from dac_code.
`timescale 1ns/1ps
module testbench
	import acs_pkg::*;
;
	logic mclk = 1'b0, rst = 1'b1, start_ctl = 1'b0, irq_clear = 1'b0;
	logic global_irq_enable = 1'b0, conv_irq_enable = 1'b0;
	acs_cfg_t cfg = '0;
	logic [11:0] vin = 12'h000, dac_code;
	acs_analog_t analog_ctl;
	logic conv_busy_flag, conv_irq_request, irq_out;
	logic [7:0] result_high_byte, result_low_byte;
	int n_fail = 0, cmp_count = 0;
	// Ideal comparator: keep the trial bit while the code stays at or below the input
	wire logic comp_out = (dac_code <= vin);
	acs_sequencer u_acs_sequencer (.mclk, .rst, .cfg, .start_ctl, .global_irq_enable,
		.conv_irq_enable, .irq_clear, .comp_out, .analog_ctl, .dac_code, .conv_busy_flag,
		.conv_irq_request, .irq_out, .result_high_byte, .result_low_byte);
	always #20 mclk = ~mclk;
	task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s exp %h got %h", nm, exp, got);
		end
	endtask
	task stop_test;
		$display("checks %0d errors %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task pulse;
		start_ctl = 1'b1;
		repeat (2) @(negedge mclk);
		start_ctl = 1'b0;
	endtask
	task wait_conv(input int per, input int post, input int pre);
		int n;
		n = 0;
		while (conv_busy_flag !== 1'b1 && n < 8) begin
			@(negedge mclk);
			n++;
		end
		@(negedge mclk);
		chk("busy_up", 16'h1, conv_busy_flag);
		chk("use_pin", cfg.internal_source_sel == 3'h0, analog_ctl.use_pin);
		chk("ref_bg", cfg.reference_source_sel inside {[4'hA:4'hC]}, analog_ctl.ref_bandgap);
		chk("ref_ext", cfg.reference_source_sel inside {[4'h1:4'h4]}, analog_ctl.ref_ext_pin);
		chk("sampling", 16'h1, analog_ctl.sample_en);
		n = 0;
		while (conv_busy_flag === 1'b1 && n < 5000) begin
			@(negedge mclk);
			n++;
		end
		if (n >= 5000) begin
			n_fail++;
			stop_test();
		end
		chk("busy_len", 16'h1, n + pre >= 15 * per && n + pre < 16 * per);
		repeat (post) @(negedge mclk);
	endtask
	initial begin
		repeat (2) @(negedge mclk);
		rst = 1'b0;
		chk("out_rst", 16'h0, {result_high_byte, result_low_byte});
		pulse();
		repeat (4) @(negedge mclk);
		chk("busy_off", 16'h0, conv_busy_flag);
		cfg.converter_power_enable = 1'b1;
		cfg.result_format_sel = 1'b1;
		global_irq_enable = 1'b1;
		conv_irq_enable = 1'b1;
		vin = 12'hFFF;
		pulse();
		wait_conv(1, 5, 0);
		chk("res_f1", 16'h0FFF, {result_high_byte, result_low_byte});
		chk("flag_irq", 16'h3, {conv_irq_request, irq_out});
		irq_clear = 1'b1;
		@(negedge mclk);
		irq_clear = 1'b0;
		repeat (2) @(negedge mclk);
		chk("flag_clr", 16'h0, {conv_irq_request, irq_out});
		global_irq_enable = 1'b0;
		cfg.result_format_sel = 1'b0;
		cfg.conv_clock_divider_sel = 3'h1;
		cfg.reference_source_sel = 4'hA;
		vin = 12'hABC;
		pulse();
		wait_conv(2, 7, 0);
		chk("res_f0", 16'hABC0, {result_high_byte, result_low_byte});
		chk("irq_mask", 16'h0, irq_out);
		// Abort mid-run by a new rise, then relaunch on its fall
		cfg.internal_source_sel = 3'h3;
		vin = 12'h123;
		pulse();
		repeat (12) @(negedge mclk);
		start_ctl = 1'b1;
		repeat (2) @(negedge mclk);
		chk("abort", 16'h0, conv_busy_flag);
		start_ctl = 1'b0;
		wait_conv(2, 7, 0);
		chk("res_src", 16'h1230, {result_high_byte, result_low_byte});
		pulse();
		repeat (6) @(negedge mclk);
		cfg.converter_power_enable = 1'b0;
		repeat (2) @(negedge mclk);
		chk("off", 16'h0, {conv_busy_flag, analog_ctl});
		pulse();
		repeat (4) @(negedge mclk);
		chk("res_kept", 16'h1230, {result_high_byte, result_low_byte});
		// Restart inside the half-clock window alters the stored word
		cfg.converter_power_enable = 1'b1;
		cfg.reference_source_sel = 4'h2;
		cfg.conv_clock_divider_sel = 3'h3;
		vin = 12'h456;
		repeat (2) @(negedge mclk);
		pulse();
		wait_conv(8, 0, 0);
		pulse();
		repeat (12) @(negedge mclk);
		chk("altered", 16'h0, {result_high_byte, result_low_byte});
		// Busy rose 11 cycles before this call, so the count starts late
		wait_conv(8, 19, 11);
		chk("res_late", 16'h4560, {result_high_byte, result_low_byte});
		stop_test();
	end
endmodule
bind acs_sequencer acs_sva u_acs_sva (.mclk, .rst, .cfg, .start_ctl, .global_irq_enable,
	.conv_irq_enable, .irq_clear, .analog_ctl, .conv_busy_flag, .conv_irq_request,
	.irq_out, .result_high_byte, .result_low_byte);
